// File: logic/tap_pkg.sv
`default_nettype none
package tap_pkg;
  // tap controller states, standard 4-bit encoding
  typedef enum logic [3:0] {
    ST_RESET    = 4'h0,
    ST_IDLE     = 4'h1,
    ST_SEL_DR   = 4'h2,
    ST_CAP_DR   = 4'h3,
    ST_SHIFT_DR = 4'h4,
    ST_EXIT1_DR = 4'h5,
    ST_PAUSE_DR = 4'h6,
    ST_EXIT2_DR = 4'h7,
    ST_UPD_DR   = 4'h8,
    ST_SEL_IR   = 4'h9,
    ST_CAP_IR   = 4'hA,
    ST_SHIFT_IR = 4'hB,
    ST_EXIT1_IR = 4'hC,
    ST_PAUSE_IR = 4'hD,
    ST_EXIT2_IR = 4'hE,
    ST_UPD_IR   = 4'hF
  } tap_state_t;

  localparam int          IR_WIDTH     = 8;
  localparam logic [7:0]  IR_CAPTURE   = 8'h81;   // fixed pattern 10000001
  localparam logic [7:0]  IR_BYPASS    = 8'hFF;   // all-ones instruction
  localparam logic [7:0]  IR_RESET_VAL = 8'hFF;   // bypass after reset
  localparam logic        BYPASS_CAP   = 1'b0;
  localparam int          DR_WIDTH     = 8;       // user data register length
  localparam int          SYNC_STAGES  = 3;
  localparam logic        TCK_IDLE     = 1'b1;    // tck rests high between scans
endpackage
`default_nettype wire

// File: logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter logic RST_LVL = 1'b0  // resting level of the pin, so reset shows no edge
)
(
  input  wire logic mclk,   // system clock
  input  wire logic rst,    // sync reset
  input  wire logic ce,     // clock enable
  input  wire logic pin,    // asynchronous pin
  output var  logic level,  // filtered level
  output var  logic rise,   // one-cycle rising pulse
  output var  logic fall    // one-cycle falling pulse
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // stage 0 is only read by stage 1; stages 1 and 2 must agree
  always_comb
  begin
    next_stage = {stage[1:0], pin};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage <= {3{RST_LVL}};
      level <= RST_LVL;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else if (ce)
    begin
      stage <= next_stage;
      level <= next_level;
      rise  <= next_level & ~level;
      fall  <= ~next_level & level;
    end
  end
endmodule
`default_nettype wire

// File: logic/tap_bypass.sv
// Contract
// - In Update-IR the shifted instruction becomes active on the falling TCK edge.
// - With bypass active, leaving Capture-DR loads zero into the bypass stage on rising TCK.
// - On the falling edge after entering a shift state TDO is driven; the host gives TDI then.
// - The first bit is taken from TDI on the rising edge leaving the first shift cycle.
// - In bypass each TDI bit appears on TDO one TCK later, the captured zero first.
// - On the falling TCK edge in Exit1-DR TDO is released.
// - In Update-DR the shifted data moves to the update stage on the falling TCK edge.
// - TDI and TMS are sampled on rising TCK, TDO changes on falling TCK; host moves TMS on falling.
// - Leaving Capture-IR on rising TCK loads 10000001 into the instruction shifter.
`timescale 1ns/1ns
`default_nettype none
module tap_bypass #(
  parameter int DR_W = tap_pkg::DR_WIDTH
)
(
  input  wire logic            mclk,      // system clock, 250 MHz
  input  wire logic            rst,       // sync reset, active high
  input  wire logic            ce,        // clock enable
  input  wire logic            tck,       // test clock pin
  input  wire logic            tms,       // test mode select pin
  input  wire logic            tdi,       // test data in pin
  output var  logic            tdoOut,    // test data out value
  output var  logic            tdoOe,     // high while tdo is driven
  output var  logic [7:0]      activeIr,  // active instruction
  output var  logic [DR_W-1:0] userData,  // update stage of data register
  output var  logic [3:0]      tapState   // controller state
);
  tap_pkg::tap_state_t state;
  tap_pkg::tap_state_t next_state;
  logic                tckRise;
  logic                tckFall;
  logic                tmsLvl;
  logic                tdiLvl;
  logic [7:0]          irShift;
  logic [7:0]          next_irShift;
  logic [DR_W-1:0]     drShift;
  logic [DR_W-1:0]     next_drShift;
  logic                bypassBit;
  logic                next_bypassBit;
  logic [7:0]          next_activeIr;
  logic [DR_W-1:0]     next_userData;
  logic                next_tdoOut;
  logic                next_tdoOe;
  logic                isBypass;

  // tck edges found by oversampling; tck must stay well below mclk / 4
  // tck rests high, so its synchroniser starts high: a low start would
  // report a false rising edge right after reset
  pin_sync #(
    .RST_LVL (tap_pkg::TCK_IDLE)
  ) u_tck (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .pin   (tck),
    .level (),
    .rise  (tckRise),
    .fall  (tckFall)
  );

  // tms level, only read when a tck edge is seen
  pin_sync u_tms (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .pin   (tms),
    .level (tmsLvl),
    .rise  (),
    .fall  ()
  );

  // tdi level, only read when a tck edge is seen
  pin_sync u_tdi (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .pin   (tdi),
    .level (tdiLvl),
    .rise  (),
    .fall  ()
  );

  // tms and tdi pass the same delay as tck, so levels at tckRise hold rising-edge values
  assign isBypass = (activeIr == tap_pkg::IR_BYPASS);

  // state walk on rising tck
  always_comb
  begin
    next_state = state;
    if (tckRise)
    begin
      case (state)
        tap_pkg::ST_RESET:    next_state = tmsLvl ? tap_pkg::ST_RESET   : tap_pkg::ST_IDLE;
        tap_pkg::ST_IDLE:     next_state = tmsLvl ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
        tap_pkg::ST_SEL_DR:   next_state = tmsLvl ? tap_pkg::ST_SEL_IR  : tap_pkg::ST_CAP_DR;
        tap_pkg::ST_CAP_DR:   next_state = tmsLvl ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_SHIFT_DR: next_state = tmsLvl ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_EXIT1_DR: next_state = tmsLvl ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_PAUSE_DR;
        tap_pkg::ST_PAUSE_DR: next_state = tmsLvl ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
        tap_pkg::ST_EXIT2_DR: next_state = tmsLvl ? tap_pkg::ST_UPD_DR  : tap_pkg::ST_SHIFT_DR;
        tap_pkg::ST_UPD_DR:   next_state = tmsLvl ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
        tap_pkg::ST_SEL_IR:   next_state = tmsLvl ? tap_pkg::ST_RESET   : tap_pkg::ST_CAP_IR;
        tap_pkg::ST_CAP_IR:   next_state = tmsLvl ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_SHIFT_IR: next_state = tmsLvl ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_EXIT1_IR: next_state = tmsLvl ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_PAUSE_IR;
        tap_pkg::ST_PAUSE_IR: next_state = tmsLvl ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
        tap_pkg::ST_EXIT2_IR: next_state = tmsLvl ? tap_pkg::ST_UPD_IR  : tap_pkg::ST_SHIFT_IR;
        tap_pkg::ST_UPD_IR:   next_state = tmsLvl ? tap_pkg::ST_SEL_DR  : tap_pkg::ST_IDLE;
        default:              next_state = tap_pkg::ST_RESET;
      endcase
    end
  end

  // shifters capture and shift on rising tck, using the state being left
  always_comb
  begin
    next_irShift   = irShift;
    next_drShift   = drShift;
    next_bypassBit = bypassBit;
    if (tckRise)
    begin
      case (state)
        tap_pkg::ST_CAP_IR:   next_irShift = tap_pkg::IR_CAPTURE;
        tap_pkg::ST_SHIFT_IR: next_irShift = {tdiLvl, irShift[7:1]};
        tap_pkg::ST_CAP_DR:
        begin
          if (isBypass)
            next_bypassBit = tap_pkg::BYPASS_CAP;
          else
            next_drShift = userData;
        end
        tap_pkg::ST_SHIFT_DR:
        begin
          if (isBypass)
            next_bypassBit = tdiLvl;
          else
            next_drShift = {tdiLvl, drShift[DR_W-1:1]};
        end
        default:              next_irShift = irShift;
      endcase
    end
  end

  // updates and tdo move on falling tck, in the state just entered; Test-Logic-Reset loads activeIr at once, without a tck edge
  always_comb
  begin
    next_activeIr = activeIr;
    next_userData = userData;
    next_tdoOut   = tdoOut;
    next_tdoOe    = tdoOe;
    if (state == tap_pkg::ST_RESET)
      next_activeIr = tap_pkg::IR_RESET_VAL;
    if (tckFall)
    begin
      case (state)
        tap_pkg::ST_SHIFT_IR:
        begin
          next_tdoOut = irShift[0];
          next_tdoOe  = 1'b1;
        end
        tap_pkg::ST_SHIFT_DR:
        begin
          next_tdoOut = isBypass ? bypassBit : drShift[0];
          next_tdoOe  = 1'b1;
        end
        tap_pkg::ST_UPD_IR:   next_activeIr = irShift;
        tap_pkg::ST_UPD_DR:
        begin
          if (!isBypass)
            next_userData = drShift;
          next_tdoOe = 1'b0;
        end
        tap_pkg::ST_EXIT1_IR,
        tap_pkg::ST_EXIT1_DR: next_tdoOe = 1'b0;
        default:              next_tdoOe = 1'b0;
      endcase
    end
  end

  // controller state; tapState is a copy so the status port leaves a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state    <= tap_pkg::ST_RESET;
      tapState <= tap_pkg::ST_RESET;
    end
    else if (ce)
    begin
      state    <= next_state;
      tapState <= next_state;
    end
  end

  // shift stages; contents before the first capture are never shown
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irShift   <= tap_pkg::IR_RESET_VAL;
      drShift   <= '0;
      bypassBit <= 1'b0;
    end
    else if (ce)
    begin
      irShift   <= next_irShift;
      drShift   <= next_drShift;
      bypassBit <= next_bypassBit;
    end
  end

  // update stages and tdo; tdoOut keeps its last bit while released,
  // only tdoOe tells whether the pin is driven
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      activeIr <= tap_pkg::IR_RESET_VAL;
      userData <= '0;
      tdoOut   <= 1'b0;
      tdoOe    <= 1'b0;
    end
    else if (ce)
    begin
      activeIr <= next_activeIr;
      userData <= next_userData;
      tdoOut   <= next_tdoOut;
      tdoOe    <= next_tdoOe;
    end
  end
endmodule
`default_nettype wire

// File: sim/tap_bypass_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tap_bypass_asserts #(parameter int DR_W = 8)
(
  input wire logic            mclk,     // clock
  input wire logic            rst,      // reset
  input wire logic            ce,       // enable
  input wire logic            tck,      // test clock
  input wire logic            tms,      // mode select
  input wire logic            tdi,      // data in
  input wire logic            tdoOut,   // data out
  input wire logic            tdoOe,    // out enable
  input wire logic [7:0]      activeIr, // instruction
  input wire logic [DR_W-1:0] userData, // update stage
  input wire logic [3:0]      tapState  // state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // a state entered this cycle
  sequence s_enter(logic [3:0] st);
    $changed(tapState) && tapState == st;
  endsequence
  sequence s_oe_on(logic [3:0] st);
    $rose(tdoOe) && tapState == st;
  endsequence
  a_oe_rise_shift: assert property ($rose(tdoOe) |-> tapState inside {4'h4, 4'hB})
    else $error("tdo enabled outside a shift state");
  a_oe_fall_exit: assert property ($fell(tdoOe) |-> tapState inside {4'h5, 4'hC})
    else $error("tdo released outside exit1");
  a_ir_update: assert property ($changed(activeIr) |-> ##[0:1] tapState inside {4'hF, 4'h0})
    else $error("instruction changed outside update");
  a_dr_update: assert property ($changed(userData) |-> tapState == 4'h8 && activeIr != 8'hFF)
    else $error("user data changed outside update");
  a_bypass_first: assert property (s_oe_on(4'h4) and activeIr == 8'hFF |-> tdoOut == 1'b0)
    else $error("bypass first bit not zero");
  a_ir_capture: assert property (s_oe_on(4'hB) |-> tdoOut == 1'b1)
    else $error("capture pattern bit 0 wrong");
  a_reset_path: assert property (s_enter(4'h0) |-> $past(tapState) == 4'h9)
    else $error("reset not entered from select ir");
  a_sel_ir_path: assert property (s_enter(4'h9) |-> $past(tapState) == 4'h2)
    else $error("select ir not entered from select dr");
endmodule
bind tap_bypass tap_bypass_asserts #(.DR_W(DR_W)) chk (.mclk(mclk), .rst(rst), .ce(ce),
  .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .activeIr(activeIr),
  .userData(userData), .tapState(tapState));
`default_nettype wire

// File: sim/scan_host.sv
`timescale 1ns/1ns
`default_nettype none
module scan_host
(
  input wire logic mclk,   // clock
  input wire logic tdoOut, // data out
  input wire logic tdoOe,  // out enable
  output var logic tck,    // test clock
  output var logic tms,    // mode select
  output var logic tdi     // data in
);
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck cycle of 12 mclk; tck parks high between calls
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    @(posedge mclk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (6) @(posedge mclk);
    tck <= 1'b1;
    repeat (5) @(posedge mclk);
    o = tdoOe ? tdoOut : ~tdoOut; // no pull on tdo: a released line reads inverted
    e = tdoOe;
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       mclk, rst, ce, tck, tms, tdi, tdoOut, tdoOe, o, e;
  logic [7:0] activeIr, userData, got, d1, ins, xp;
  logic [3:0] tapState;
  logic       bq[$];
  int         num_errors, checked;
  always #2 mclk = ~mclk;
  tap_bypass #(.DR_W(8)) dut (.mclk(mclk), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
    .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .activeIr(activeIr), .userData(userData),
    .tapState(tapState));
  scan_host host (.mclk(mclk), .tdoOut(tdoOut), .tdoOe(tdoOe), .tck(tck), .tms(tms), .tdi(tdi));
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x)
    begin
      $display("Error %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  // from idle: one scan of n bits, ends in update then tms=fin
  task automatic scan(input logic ir, input int n, input logic [7:0] din, input logic fin,
                      output logic [7:0] dout);
    dout = 8'h00;
    host.step(1'b1, 1'b0, o, e);
    if (ir)
      host.step(1'b1, 1'b0, o, e);
    host.step(1'b0, 1'b0, o, e);
    host.step(1'b0, 1'b0, o, e);
    for (int i = 0; i < n; i++)
    begin
      host.step(i == n - 1, din[i], o, e);
      dout[i] = o;
      chk("tdoOe", 8'h01, {7'h00, e});
    end
    host.step(1'b1, 1'b0, o, e);
    chk("tdoOe", 8'h00, {7'h00, e});
    host.step(fin, 1'b0, o, e);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    test_done;
  end
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    void'($urandom(95));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("activeIr", 8'hFF, activeIr);
    host.step(1'b0, 1'b0, o, e);
    ins = 8'($urandom % 255);
    scan(1'b1, 8, ins, 1'b0, got);
    chk("ir out", tap_pkg::IR_CAPTURE, got);
    chk("activeIr", ins, activeIr);
    // a frozen block must miss a whole tck cycle
    ce <= 1'b0;
    host.step(1'b1, 1'b0, o, e);
    ce <= 1'b1;
    chk("tapState", {4'h0, tap_pkg::ST_IDLE}, {4'h0, tapState});
    // user register: out shows the previous update
    xp = 8'h00;
    repeat (2)
    begin
      d1 = 8'($urandom);
      scan(1'b0, 8, d1, 1'b0, got);
      chk("dr out", xp, got);
      chk("userData", d1, userData);
      xp = d1;
    end
    scan(1'b1, 8, tap_pkg::IR_BYPASS, 1'b0, got);
    chk("ir out", tap_pkg::IR_CAPTURE, got);
    chk("activeIr", 8'hFF, activeIr);
    // bypass model: queue primed with the captured zero
    for (int k = 0; k < 2; k++)
    begin
      // bit 7 set, so the second capture has a one to clear
      ins = k ? 8'h05 : 8'($urandom) | 8'h80;
      bq = {1'b0};
      xp = 8'h00;
      for (int i = 0; i < (k ? 3 : 8); i++)
      begin
        bq.push_back(ins[i]);
        xp[i] = bq.pop_front();
      end
      scan(1'b0, k ? 3 : 8, ins, 1'b0, got);
      chk("bypass out", xp, got);
      chk("userData", d1, userData);
    end
    // non-bypass again, so the reset walk has an instruction to clear
    ins = 8'($urandom % 255);
    scan(1'b1, 8, ins, 1'b0, got);
    chk("activeIr", ins, activeIr);
    xp = d1;
    d1 = 8'($urandom);
    scan(1'b0, 8, d1, 1'b1, got);
    chk("dr out", xp, got);
    chk("userData", d1, userData);
    host.step(1'b1, 1'b0, o, e);
    host.step(1'b1, 1'b0, o, e);
    repeat (4) @(posedge mclk);
    chk("tapState", 8'h00, {4'h0, tapState});
    chk("activeIr", 8'hFF, activeIr);
    test_done;
  end
endmodule
`default_nettype wire
